// ==== rtl/dstm_pkg.sv ====
// Shared constants and types for the direct speed mode transfer sequencer.
package dstm_pkg;

  // ---------------------------------------------------------------
  // Mode encoding
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    DSTM_MODE_HIGH   = 3'h0,
    DSTM_MODE_MEDIUM = 3'h1,
    DSTM_MODE_SUB    = 3'h2,
    DSTM_MODE_SLEEP  = 3'h3,
    DSTM_MODE_WATCH  = 3'h4
  } dstm_mode_e;

  // ---------------------------------------------------------------
  // Sequencer states, Gray coded along the subactive exit path through SETTLE
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    DSTM_ST_RUN    = 3'h0,
    DSTM_ST_PRE    = 3'h1,
    DSTM_ST_SETTLE = 3'h3,
    DSTM_ST_EXC    = 3'h2,
    DSTM_ST_HALT   = 3'h6
  } dstm_state_e;

  // ---------------------------------------------------------------
  // Timing counts in states of the governing clock, clock dividers and counter width
  // ---------------------------------------------------------------
  localparam int unsigned DSTM_SLEEP_STATES = 2;
  localparam int unsigned DSTM_INTERNAL_STATES = 1;
  localparam int unsigned DSTM_PRE_STATES =
    DSTM_SLEEP_STATES + DSTM_INTERNAL_STATES;
  localparam int unsigned DSTM_EXC_STATES = 14;
  localparam int unsigned DSTM_MEDIUM_DIV = 8;
  localparam int unsigned DSTM_SUB_DIV_DEFAULT = 8;
  localparam int unsigned DSTM_CNT_W = 17;

  // Settling wait in states for each settling_time_select code.
  localparam logic [16:0] DSTM_WAIT_0 = 17'h02000;
  localparam logic [16:0] DSTM_WAIT_1 = 17'h04000;
  localparam logic [16:0] DSTM_WAIT_2 = 17'h08000;
  localparam logic [16:0] DSTM_WAIT_3 = 17'h10000;
  localparam logic [16:0] DSTM_WAIT_4 = 17'h00800;
  localparam logic [16:0] DSTM_WAIT_5 = 17'h00400;
  localparam logic [16:0] DSTM_WAIT_6 = 17'h00200;
  localparam logic [16:0] DSTM_WAIT_7 = 17'h00100;

endpackage : dstm_pkg

// ==== rtl/dstm_tick_div.sv ====
// Clock-state tick generator dividing the oscillator clock by a ratio.
`timescale 1ns/100ps
`default_nettype none
module dstm_tick_div
  import dstm_pkg::*;
#(
  parameter int unsigned WIDTH = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic restart,
  input wire logic [WIDTH-1:0] ratio,
  output logic tick
);

  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;

  // ---------------------------------------------------------------
  // Divider
  // ---------------------------------------------------------------
  // Restart realigns the state boundary when the clock source changes.
  always_comb begin
    count_nxt = count_r + {{(WIDTH-1){1'b0}}, 1'b1};
    if (restart || (count_r + {{(WIDTH-1){1'b0}}, 1'b1} >= ratio)) begin
      count_nxt = '0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  // A state ends on the last oscillator cycle of the divided period.
  // The tick depends on the count and ratio alone: the sequencer's next state reads
  // it and restart comes from that next state, so gating the tick with
  // restart would close a combinational loop.
  assign tick = (count_r + {{(WIDTH-1){1'b0}}, 1'b1} >= ratio);

endmodule : dstm_tick_div
`default_nettype wire

// ==== rtl/dstm_seq.sv ====
// Direct speed mode transfer sequencer between the executing modes.
//
// Behaviour
// [RULE1] SLEEP in high-speed with standby_select=0, low_speed_on=0, medium_speed_on=1, direct_transfer_on=1 goes to medium-speed.
// [RULE2] SLEEP in medium-speed with standby_select, low_speed_on, medium_speed_on all 0 and direct_transfer_on=1 goes to high-speed.
// [RULE3] SLEEP in subactive with standby_select=1, low_speed_on=0, medium_speed_on=0, direct_transfer_on=1, timer_a_mode_bit3=1 goes to high-speed.
// [RULE4] SLEEP in subactive with standby_select=1, low_speed_on=0, medium_speed_on=1, direct_transfer_on=1, timer_a_mode_bit3=1 goes to medium-speed.
// [RULE5] A transfer takes 2 SLEEP states and 1 internal state on the old clock, then 14 exception states on the new clock.
// [RULE6] Leaving subactive, the old states count on the subclock and the selected settling wait runs on the new clock before exception handling.
// [RULE7] Any transfer into or out of subactive passes through watch mode.
// [RULE8] After the mode change the direct transfer interrupt exception handling starts without halting execution.
// [RULE9] With the transfer interrupt disabled or interrupts masked, sleep or watch mode is entered instead.
// [RULE10] In medium-speed mode the CPU clock is one eighth of the high-speed rate.
`timescale 1ns/100ps
`default_nettype none
module dstm_seq
  import dstm_pkg::*;
#(
  parameter int unsigned SUB_DIV = DSTM_SUB_DIV_DEFAULT
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sleep_exec,
  input wire logic standby_select,
  input wire logic low_speed_on,
  input wire logic medium_speed_on,
  input wire logic direct_transfer_on,
  input wire logic timer_a_mode_bit3,
  input wire logic [2:0] settling_time_select,
  input wire logic direct_irq_enable,
  input wire logic irq_masked,
  input wire logic wake_event,
  output logic [2:0] mode,
  output logic cpu_state_tick,
  output logic seq_busy,
  output logic watch_active,
  output logic settle_active,
  output logic exc_start,
  output logic exc_active
);

  dstm_state_e state_r;
  dstm_state_e state_nxt;
  dstm_mode_e mode_r;
  dstm_mode_e mode_nxt;
  dstm_mode_e target_r;
  dstm_mode_e target_nxt;
  logic [DSTM_CNT_W-1:0] cnt_r;
  logic [DSTM_CNT_W-1:0] cnt_nxt;
  logic exc_start_r;
  logic exc_start_nxt;
  logic watch_r;
  logic watch_nxt;
  logic restart;
  logic tick;
  logic [3:0] ratio;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Oscillator cycles per CPU state for a given executing mode.
  function automatic logic [3:0] dstm_ratio(input dstm_mode_e m);
    if (m == DSTM_MODE_MEDIUM) begin
      dstm_ratio = 4'(DSTM_MEDIUM_DIV); // [RULE10]
    end else if (m == DSTM_MODE_SUB) begin
      dstm_ratio = 4'(SUB_DIV); // [RULE6]
    end else begin
      dstm_ratio = 4'h1;
    end
  endfunction

  // Settling wait length in states for a select code.
  function automatic logic [DSTM_CNT_W-1:0] dstm_wait(input logic [2:0] s);
    case (s)
      3'h0: dstm_wait = DSTM_WAIT_0;
      3'h1: dstm_wait = DSTM_WAIT_1;
      3'h2: dstm_wait = DSTM_WAIT_2;
      3'h3: dstm_wait = DSTM_WAIT_3;
      3'h4: dstm_wait = DSTM_WAIT_4;
      3'h5: dstm_wait = DSTM_WAIT_5;
      3'h6: dstm_wait = DSTM_WAIT_6;
      default: dstm_wait = DSTM_WAIT_7;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // State clock
  // ---------------------------------------------------------------
  // The state length follows the mode in force, so old-clock states are
  // timed before the switch and new-clock states after it.
  assign ratio = dstm_ratio(mode_r); // [RULE5]
  assign restart = (state_nxt != state_r) || (mode_nxt != mode_r);

  dstm_tick_div #(
    .WIDTH(4)
  ) u_tick (
    .clk(clk),
    .reset_n(reset_n),
    .restart(restart),
    .ratio(ratio),
    .tick(tick)
  );

  // ---------------------------------------------------------------
  // Sequencer next state
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    mode_nxt = mode_r;
    target_nxt = target_r;
    cnt_nxt = cnt_r;
    exc_start_nxt = 1'b0;
    watch_nxt = watch_r;
    case (state_r)
      DSTM_ST_RUN: begin
        if (sleep_exec && direct_transfer_on) begin
          state_nxt = DSTM_ST_PRE;
          cnt_nxt = '0;
          if (mode_r == DSTM_MODE_HIGH && !standby_select && !low_speed_on
              && medium_speed_on) begin
            target_nxt = DSTM_MODE_MEDIUM; // [RULE1]
          end else if (mode_r == DSTM_MODE_MEDIUM && !standby_select &&
                       !low_speed_on && !medium_speed_on) begin
            target_nxt = DSTM_MODE_HIGH; // [RULE2]
          end else if (mode_r == DSTM_MODE_SUB && standby_select &&
                       !low_speed_on && timer_a_mode_bit3) begin
            // [RULE3] [RULE4]
            target_nxt = medium_speed_on ? DSTM_MODE_MEDIUM : DSTM_MODE_HIGH;
          end else if (mode_r != DSTM_MODE_SUB && standby_select &&
                       low_speed_on && timer_a_mode_bit3) begin
            target_nxt = DSTM_MODE_SUB;
          end else begin
            // Combinations with no direct path leave the mode unchanged.
            state_nxt = DSTM_ST_RUN;
          end
        end
      end
      DSTM_ST_PRE: begin
        if (tick) begin
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_r == DSTM_CNT_W'(DSTM_PRE_STATES - 1)) begin // [RULE5]
            cnt_nxt = '0;
            watch_nxt = (mode_r == DSTM_MODE_SUB) ||
                        (target_r == DSTM_MODE_SUB); // [RULE7]
            if (!direct_irq_enable || irq_masked) begin
              // [RULE9]
              state_nxt = DSTM_ST_HALT;
              mode_nxt = (standby_select && timer_a_mode_bit3) ?
                         DSTM_MODE_WATCH : DSTM_MODE_SLEEP;
            end else begin
              mode_nxt = target_r;
              state_nxt = (mode_r == DSTM_MODE_SUB) ? DSTM_ST_SETTLE
                                                    : DSTM_ST_EXC;
              exc_start_nxt = (mode_r != DSTM_MODE_SUB); // [RULE8]
            end
          end
        end
      end
      DSTM_ST_SETTLE: begin
        // The wait runs on the new clock while the oscillator settles.
        if (tick) begin
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_r == dstm_wait(settling_time_select) - 1'b1) begin // [RULE6]
            cnt_nxt = '0;
            state_nxt = DSTM_ST_EXC;
            exc_start_nxt = 1'b1; // [RULE8]
            watch_nxt = 1'b0;
          end
        end
      end
      DSTM_ST_EXC: begin
        watch_nxt = 1'b0;
        if (tick) begin
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_r == DSTM_CNT_W'(DSTM_EXC_STATES - 1)) begin // [RULE5]
            cnt_nxt = '0;
            state_nxt = DSTM_ST_RUN;
          end
        end
      end
      DSTM_ST_HALT: begin
        // Only an external wake leaves sleep or watch; masked interrupts
        // cannot do it, which the CPU must take care to avoid.
        watch_nxt = 1'b0;
        if (wake_event && !irq_masked) begin
          state_nxt = DSTM_ST_RUN;
          mode_nxt = target_r;
        end
      end
      default: begin
        state_nxt = DSTM_ST_RUN;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Sequencer registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= DSTM_ST_RUN;
      mode_r <= DSTM_MODE_HIGH;
      target_r <= DSTM_MODE_HIGH;
      cnt_r <= '0;
      exc_start_r <= 1'b0;
      watch_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      mode_r <= mode_nxt;
      target_r <= target_nxt;
      cnt_r <= cnt_nxt;
      exc_start_r <= exc_start_nxt;
      watch_r <= watch_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign mode = mode_r;
  assign cpu_state_tick = tick;
  assign seq_busy = (state_r != DSTM_ST_RUN);
  assign watch_active = watch_r; // [RULE7]
  assign settle_active = (state_r == DSTM_ST_SETTLE);
  assign exc_start = exc_start_r;
  assign exc_active = (state_r == DSTM_ST_EXC);

endmodule : dstm_seq
`default_nettype wire

// ==== dv/dstm_seq_sva.sv ====
// Port timing checker bound to the transfer sequencer.
`timescale 1ns/100ps
`default_nettype none
module dstm_seq_sva
  import dstm_pkg::*;
#(
  parameter int unsigned SUB_DIV = DSTM_SUB_DIV_DEFAULT
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sleep_exec,
  input wire logic standby_select,
  input wire logic low_speed_on,
  input wire logic medium_speed_on,
  input wire logic direct_transfer_on,
  input wire logic timer_a_mode_bit3,
  input wire logic direct_irq_enable,
  input wire logic irq_masked,
  input wire logic [2:0] mode,
  input wire logic cpu_state_tick,
  input wire logic seq_busy,
  input wire logic watch_active,
  input wire logic settle_active,
  input wire logic exc_start,
  input wire logic exc_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // A taken SLEEP, and one that interrupt gating does not divert.
  wire logic go = sleep_exec && direct_transfer_on && !seq_busy;
  wire logic ok = go && direct_irq_enable && !irq_masked;
  wire logic act = !standby_select && !low_speed_on;
  a_high_med: assert property (
    ok && act && medium_speed_on && mode == 3'h0 |=>
    seq_busy ##3 (mode == 3'h1 && exc_start)) else $error("high to med");
  a_med_high: assert property (
    ok && act && !medium_speed_on && mode == 3'h1 |=>
    seq_busy ##[17:25] (mode == 3'h0 && exc_start)) else $error("med to high");
  a_via_watch: assert property (
    ok && standby_select && timer_a_mode_bit3 &&
    (low_speed_on ? mode != 3'h2 : mode == 3'h2) |-> ##[1:40] watch_active)
    else $error("no watch phase");
  a_exc_high: assert property (
    exc_start && mode == 3'h0 |-> ##13 exc_active ##1 !seq_busy)
    else $error("high exception length");
  a_exc_med: assert property (
    exc_start && mode == 3'h1 |-> ##111 exc_active ##1 !seq_busy)
    else $error("medium exception length");
  a_med_tick: assert property (
    mode == 3'h1 && !seq_busy && cpu_state_tick |=>
    !cpu_state_tick [*7] ##1 cpu_state_tick) else $error("medium tick");
  a_settle_end: assert property (
    $fell(settle_active) |-> ##[0:1] exc_start) else $error("settle end");
  a_refused: assert property (
    go && !direct_irq_enable && act && medium_speed_on && mode == 3'h0
    |-> ##[1:6] mode == 3'h3) else $error("refused not asleep");
endmodule // dstm_seq_sva
bind dstm_seq dstm_seq_sva #(.SUB_DIV(SUB_DIV)) dstm_seq_sva_i (.*);
`default_nettype wire

// ==== dv/dstm_cpu_model.sv ====
// Model of the CPU core that executes SLEEP and raises wake requests.
`timescale 1ns/100ps
`default_nettype none
module dstm_cpu_model (
  input wire logic clk,
  input wire logic issue,
  input wire logic wake_req,
  input wire logic seq_busy,
  input wire logic cpu_state_tick,
  output logic sleep_exec = 1'b0,
  output logic wake_event = 1'b0
);
  logic armed = 1'b0;
  // SLEEP is a one-cycle strobe on the last oscillator cycle of a CPU
  // state, since an instruction only ends on a state boundary; a request
  // waits armed until then. Wake drops once the sequencer runs, as a real
  // wake source is cleared by its handler.
  always @(negedge clk) begin
    sleep_exec <= (armed || issue) && cpu_state_tick;
    armed <= (armed || issue) && !cpu_state_tick;
    wake_event <= wake_req && seq_busy;
  end
endmodule // dstm_cpu_model
`default_nettype wire

// ==== dv/dstm_seq_tb.sv ====
// Self-checking bench of the direct speed mode transfer sequencer.
`timescale 1ns/100ps
`default_nettype none
module dstm_seq_tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic issue = 1'b0;
  logic wake_req = 1'b0;
  logic standby_select = 1'b0, low_speed_on = 1'b0, medium_speed_on = 1'b0;
  logic timer_a_mode_bit3 = 1'b0, direct_irq_enable = 1'b0;
  logic irq_masked = 1'b0;
  logic direct_transfer_on = 1'b1;
  logic [2:0] settle_code = 3'h7;
  logic sleep_exec, wake_event, cpu_state_tick, seq_busy, watch_active;
  logic settle_active, exc_start, exc_active;
  logic [2:0] mode;
  logic [2:0] cur;
  logic saw_watch, saw_settle, saw_exc;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int seed = 83;
  int n;
  int settle_cycles;
  dstm_seq dstm_seq_i (.clk(clk), .reset_n(reset_n),
    .sleep_exec(sleep_exec), .standby_select(standby_select),
    .low_speed_on(low_speed_on), .medium_speed_on(medium_speed_on),
    .direct_transfer_on(direct_transfer_on),
    .timer_a_mode_bit3(timer_a_mode_bit3),
    .settling_time_select(settle_code),
    .direct_irq_enable(direct_irq_enable),
    .irq_masked(irq_masked), .wake_event(wake_event), .mode(mode),
    .cpu_state_tick(cpu_state_tick), .seq_busy(seq_busy),
    .watch_active(watch_active), .settle_active(settle_active),
    .exc_start(exc_start), .exc_active(exc_active));
  dstm_cpu_model dstm_cpu_model_i (.clk(clk), .issue(issue),
    .wake_req(wake_req), .seq_busy(seq_busy),
    .cpu_state_tick(cpu_state_tick), .sleep_exec(sleep_exec),
    .wake_event(wake_event));
  // Clock at 25 MHz.
  initial forever #20 clk = ~clk;
  // A hung transfer would stall the run, so a cycle ceiling cuts it.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      fail_count++;
    end
  endtask
  task automatic give_verdict();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // One SLEEP, cfg is {standby, low, medium, timer bit, enable, mask};
  // a refused one is woken once it has parked.
  task automatic xfer(input logic [5:0] cfg);
    logic refuse;
    logic saw_busy;
    @(negedge clk);
    {standby_select, low_speed_on, medium_speed_on, timer_a_mode_bit3,
      direct_irq_enable, irq_masked} = cfg;
    issue <= 1'b1;
    refuse = !cfg[1] || cfg[0];
    {saw_watch, saw_settle, saw_exc, saw_busy} = 4'h0;
    n = 0;
    settle_cycles = 0;
    // The model may hold SLEEP back to a state boundary, so wait for busy.
    do begin
      @(negedge clk);
      issue <= 1'b0;
      n++;
      saw_busy |= seq_busy;
      saw_watch |= watch_active;
      saw_settle |= settle_active;
      saw_exc |= exc_start;
      settle_cycles += int'(settle_active);
    end while (!saw_busy || (seq_busy && !(refuse && mode >= 3'h3)));
    if (refuse) begin
      check("halt", 16'(mode), (cfg[5] && cfg[2]) ? 16'h4 : 16'h3);
      irq_masked = 1'b0;
      wake_req = 1'b1;
      while (seq_busy) @(negedge clk);
      wake_req = 1'b0;
    end else begin
      check("exc", 16'(saw_exc), 16'h1);
    end
  endtask
  initial begin
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    // With direct transfers off a SLEEP must leave the sequencer idle.
    @(negedge clk);
    direct_transfer_on = 1'b0;
    medium_speed_on = 1'b1;
    issue <= 1'b1;
    @(negedge clk);
    issue <= 1'b0;
    repeat (4) @(negedge clk);
    check("ignored", 16'({seq_busy, mode}), 16'h0);
    direct_transfer_on = 1'b1;
    xfer(6'b001010);
    check("mode", 16'(mode), 16'h1);
    // Three old states, fourteen states of eight cycles, one cycle of strobe
    // latency through the model and the idle sample that ends the loop.
    check("length", 16'(n), 16'd117);
    xfer(6'b000010);
    check("mode", 16'(mode), 16'h0);
    xfer(6'b110110);
    check("mode", 16'(mode), 16'h2);
    check("watch", 16'(saw_watch), 16'h1);
    xfer(6'b101110);
    check("mode", 16'(mode), 16'h1);
    check("settle", 16'(saw_settle), 16'h1);
    // Code 7 is 256 states, each eight cycles in medium-speed mode.
    check("settle_len", 16'(settle_cycles), 16'd2048);
    xfer(6'b110110);
    xfer(6'b100110);
    check("mode", 16'(mode), 16'h0);
    check("watch", 16'(saw_watch), 16'h1);
    // A refused move toward subactive parks in watch, then wakes into subactive.
    xfer(6'b110100);
    check("mode", 16'(mode), 16'h2);
    // Code 6 is 512 states, one cycle each in high-speed mode.
    settle_code = 3'h6;
    xfer(6'b100110);
    check("settle_len", 16'(settle_cycles), 16'd512);
    settle_code = 3'h7;
    // Alternating direction and random gating; the awkward refused cases recur.
    for (int i = 0; i < 8; i++) begin
      cur = (mode == 3'h0) ? 3'h1 : 3'h0;
      xfer({2'h0, cur[0], 1'b0, 1'($random(seed)), 1'($random(seed))});
      check("mode", 16'(mode), 16'(cur));
    end
    give_verdict();
  end
endmodule // dstm_seq_tb
`default_nettype wire
